// [rtl/uctl_top.v]
// Serial port control registers with Avalon-MM slave, interrupt gating and line steering
`timescale 1ns/1ps
`include "uctl_defs.vh"
module uctl_top #(
  parameter ADDR_W = 6
) (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Avalon-MM slave
  input wire [ADDR_W-1:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [3:0] avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // Status flags from the serial core
  input wire receive_done_flag_i,
  input wire transmit_done_flag_i,
  input wire holding_empty_flag_i,
  input wire receive_start_flag_i,
  input wire sync_field_error_flag_i,
  // Line side
  input wire tx_data_i,
  input wire rxd_pin_i,
  output wire txd_pin_o,
  output wire txd_pin_oe_o,
  output wire rx_data_o,
  // Interrupt request
  output wire irq_o,
  // Control decodes toward the serial core
  output wire differential_transceiver_mode_o,
  output wire receiver_on_o,
  output wire transmitter_on_o,
  output wire frame_start_detect_on_o,
  output wire multiprocessor_address_filter_o,
  output wire double_speed_o,
  output wire generic_autobaud_o,
  output wire lin_constrained_autobaud_o,
  output wire async_mode_o,
  output wire sync_mode_o,
  output wire infrared_mode_o,
  output wire host_spi_mode_o,
  output wire parity_on_o,
  output wire parity_odd_o,
  output wire parity_reserved_o,
  output wire two_stop_bits_o,
  output wire [3:0] character_width_o,
  output wire nine_bit_low_first_o,
  output wire nine_bit_high_first_o,
  output wire spi_lsb_first_o,
  output wire spi_sample_trailing_o
);

  // Register storage and bus state
  reg [7:0] ctrl_a_q;
  reg [7:0] ctrl_a_d;
  reg [7:0] ctrl_b_q;
  reg [7:0] ctrl_b_d;
  reg [7:0] ctrl_c_q;
  reg [7:0] ctrl_c_d;
  reg ack_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;
  reg irq_q;
  reg rx_data_q;
  reg txd_pin_q;
  reg txd_oe_q;
  reg [20:0] dec_q;
  reg [20:0] dec_d;
  reg [3:0] width_q;
  reg [3:0] width_d;

  // Address decode; low two bits must be zero for an aligned word
  wire req = avs_read_i | avs_write_i;
  wire aligned = (avs_address_i[1:0] == 2'b00);
  wire [3:0] idx = avs_address_i[5:2];
  wire hit_a = aligned & (idx == `UCTL_IDX_CTRL_A);
  wire hit_b = aligned & (idx == `UCTL_IDX_CTRL_B);
  wire hit_c = aligned & (idx == `UCTL_IDX_CTRL_C);
  wire hit_s = aligned & (idx == `UCTL_IDX_STATUS);
  wire hit_p = aligned & (idx == `UCTL_IDX_PENDING);

  // A write lands only at the edge where waitrequest is seen low
  wire wr_go = avs_write_i & ack_q & avs_byteenable_i[0];
  // Read data is captured in the first cycle and held through the answer cycle
  wire rd_take = avs_read_i & ~ack_q;

  // Every access waits one cycle so read data can come from a flop
  assign avs_waitrequest_o = req & ~ack_q;
  assign avs_readdata_o = rdata_q;

  // Interrupt sources and their enables, in matching order
  wire [`UCTL_NUM_SRC-1:0] src_flag;
  wire [`UCTL_NUM_SRC-1:0] src_en;
  wire [`UCTL_NUM_SRC-1:0] src_pend;
  assign src_flag = {receive_done_flag_i, transmit_done_flag_i, holding_empty_flag_i,
                     receive_start_flag_i, sync_field_error_flag_i};
  assign src_en = {ctrl_a_q[`UCTL_A_RXDONE_IE], ctrl_a_q[`UCTL_A_TXDONE_IE], ctrl_a_q[`UCTL_A_HOLD_IE],
                   ctrl_a_q[`UCTL_A_START_IE], ctrl_a_q[`UCTL_A_ABERR_IE]};

  // One gate per source: a clear enable keeps its flag off the pending view and the interrupt; the status view still shows it
  genvar gi;
  generate
    for (gi = 0; gi < `UCTL_NUM_SRC; gi = gi + 1)
    begin : g_src
      assign src_pend[gi] = src_flag[gi] & src_en[gi];
    end
  endgenerate

  // Status view and pending view, both read-only
  wire [7:0] status_view = {src_flag, 3'b000};
  wire [7:0] pending_view = {src_pend, 3'b000};

  // Host SPI layout keeps only mode, order and phase bits
  wire spi_now = (ctrl_c_q[`UCTL_C_COMMUNICATION_MODE_SELECT_HI:`UCTL_C_COMMUNICATION_MODE_SELECT_LO] == `UCTL_CM_SPI);
  wire spi_next = (avs_writedata_i[`UCTL_C_COMMUNICATION_MODE_SELECT_HI:`UCTL_C_COMMUNICATION_MODE_SELECT_LO] == `UCTL_CM_SPI);
  wire [7:0] ctrl_c_view = spi_now ? (ctrl_c_q & `UCTL_MASK_CTRL_C_SPI) : ctrl_c_q;

  // Next register values from bus writes
  always @*
  begin
    ctrl_a_d = ctrl_a_q;
    ctrl_b_d = ctrl_b_q;
    ctrl_c_d = ctrl_c_q;
    if (wr_go & hit_a)
    begin
      ctrl_a_d = avs_writedata_i[7:0] & `UCTL_MASK_CTRL_A;
    end
    if (wr_go & hit_b)
    begin
      ctrl_b_d = avs_writedata_i[7:0] & `UCTL_MASK_CTRL_B;
    end
    if (wr_go & hit_c)
    begin
      // Fields outside the SPI layout are dropped so a later switch back starts clean
      if (spi_next)
      begin
        ctrl_c_d = avs_writedata_i[7:0] & `UCTL_MASK_CTRL_C_SPI;
      end
      else
      begin
        ctrl_c_d = avs_writedata_i[7:0] & `UCTL_MASK_CTRL_C;
      end
    end
  end

  // Read data mux; unmapped or misaligned words read as zero
  always @*
  begin
    rdata_d = 32'h0000_0000;
    if (hit_a)
    begin
      rdata_d[7:0] = ctrl_a_q;
    end
    else if (hit_b)
    begin
      rdata_d[7:0] = ctrl_b_q;
    end
    else if (hit_c)
    begin
      rdata_d[7:0] = ctrl_c_view;
    end
    else if (hit_s)
    begin
      rdata_d[7:0] = status_view;
    end
    else if (hit_p)
    begin
      rdata_d[7:0] = pending_view;
    end
  end

  // Mode decodes registered so the core sees glitch-free levels
  always @*
  begin
    dec_d = 21'h0_0000;
    dec_d[0] = ctrl_a_q[`UCTL_A_DIFF];
    dec_d[1] = ctrl_b_q[`UCTL_B_RX_ON];
    dec_d[2] = ctrl_b_q[`UCTL_B_TX_ON];
    dec_d[3] = ctrl_b_q[`UCTL_B_SFD_ON];
    dec_d[4] = ctrl_b_q[`UCTL_B_MULTIPROCESSOR_ADDRESS_FILTER];
    // Receiver speed taken as written; software keeps it normal in async and infrared
    dec_d[5] = (ctrl_b_q[`UCTL_B_RECEIVER_SPEED_SELECT_HI:`UCTL_B_RECEIVER_SPEED_SELECT_LO] == `UCTL_RXM_DOUBLE);
    dec_d[6] = (ctrl_b_q[`UCTL_B_RECEIVER_SPEED_SELECT_HI:`UCTL_B_RECEIVER_SPEED_SELECT_LO] == `UCTL_RXM_GENERIC_AUTOBAUD);
    dec_d[7] = (ctrl_b_q[`UCTL_B_RECEIVER_SPEED_SELECT_HI:`UCTL_B_RECEIVER_SPEED_SELECT_LO] == `UCTL_RXM_LIN_CONSTRAINED_AUTOBAUD);
    dec_d[8] = (ctrl_c_q[`UCTL_C_COMMUNICATION_MODE_SELECT_HI:`UCTL_C_COMMUNICATION_MODE_SELECT_LO] == `UCTL_CM_ASYNC);
    dec_d[9] = (ctrl_c_q[`UCTL_C_COMMUNICATION_MODE_SELECT_HI:`UCTL_C_COMMUNICATION_MODE_SELECT_LO] == `UCTL_CM_SYNC);
    dec_d[10] = (ctrl_c_q[`UCTL_C_COMMUNICATION_MODE_SELECT_HI:`UCTL_C_COMMUNICATION_MODE_SELECT_LO] == `UCTL_CM_INFRARED);
    dec_d[11] = spi_now;
    if (!spi_now)
    begin
      // Frame-format fields only mean something outside host SPI
      dec_d[12] = (ctrl_c_q[`UCTL_C_PAR_HI:`UCTL_C_PAR_LO] == `UCTL_PAR_EVEN) |
                  (ctrl_c_q[`UCTL_C_PAR_HI:`UCTL_C_PAR_LO] == `UCTL_PAR_ODD);
      dec_d[13] = (ctrl_c_q[`UCTL_C_PAR_HI:`UCTL_C_PAR_LO] == `UCTL_PAR_ODD);
      dec_d[14] = (ctrl_c_q[`UCTL_C_PAR_HI:`UCTL_C_PAR_LO] == `UCTL_PAR_RSVD);
      dec_d[15] = ctrl_c_q[`UCTL_C_STOP];
      dec_d[16] = (ctrl_c_q[`UCTL_C_SIZE_HI:`UCTL_C_SIZE_LO] == `UCTL_CS_NINE_LOW);
      dec_d[17] = (ctrl_c_q[`UCTL_C_SIZE_HI:`UCTL_C_SIZE_LO] == `UCTL_CS_NINE_HIGH);
    end
    else
    begin
      // Set order bit means the least significant bit leaves first
      dec_d[18] = ctrl_c_q[`UCTL_C_SPI_ORDER];
      dec_d[19] = ctrl_c_q[`UCTL_C_SPI_PHASE];
    end
    // Spare decode bit kept low
    dec_d[20] = 1'b0;
  end

  // Character width in data bits; reserved codes and SPI give zero
  always @*
  begin
    width_d = 4'h0;
    if (!spi_now)
    begin
      if (ctrl_c_q[2] == 1'b0)
      begin
        width_d = `UCTL_CS_WIDTH_BASE + {2'b00, ctrl_c_q[1:0]};
      end
      else if (ctrl_c_q[1] == 1'b1)
      begin
        width_d = `UCTL_CS_WIDTH_NINE;
      end
    end
  end

  // Register file and decode flops
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ctrl_a_q <= `UCTL_RST_CTRL_A;
      ctrl_b_q <= `UCTL_RST_CTRL_B;
      ctrl_c_q <= `UCTL_RST_CTRL_C;
      dec_q <= 21'h0_0000;
      width_q <= 4'h0;
    end
    else
    begin
      ctrl_a_q <= ctrl_a_d;
      ctrl_b_q <= ctrl_b_d;
      ctrl_c_q <= ctrl_c_d;
      // Decodes lag the register by one edge; the core sees only settled levels
      dec_q <= dec_d;
      width_q <= width_d;
    end
  end

  // Bus handshake: one wait cycle per access, so back-to-back requests cost two cycles each
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      // Ack toggles high for the second cycle of each request, then drops
      ack_q <= req & ~ack_q;
      if (rd_take)
      begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Interrupt request flop, held while any enabled flag stands
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |src_pend;
    end
  end

  // Receiver input steering; idles high like a quiet line so no false start follows reset
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      rx_data_q <= 1'b1;
    end
    else
    begin
      // Receive pin is cut off completely while looped back
      rx_data_q <= ctrl_a_q[`UCTL_A_LOOPBACK] ? tx_data_i : rxd_pin_i;
    end
  end

  // Transmit pin drive style
  always @(posedge clk_i)
  begin
    if (reset_i)
    begin
      txd_pin_q <= 1'b1;
      txd_oe_q <= 1'b0;
    end
    else
    begin
      if (ctrl_b_q[`UCTL_B_OPEN_DRAIN])
      begin
        // Open drain only pulls low; a pull-up must supply the high level
        txd_pin_q <= 1'b0;
        txd_oe_q <= ctrl_b_q[`UCTL_B_TX_ON] & ~tx_data_i;
      end
      else
      begin
        txd_pin_q <= tx_data_i;
        txd_oe_q <= ctrl_b_q[`UCTL_B_TX_ON];
      end
    end
  end

  // Interrupt and line outputs, all straight from flops
  assign irq_o = irq_q;
  assign rx_data_o = rx_data_q;
  assign txd_pin_o = txd_pin_q;
  assign txd_pin_oe_o = txd_oe_q;

  // Control decodes toward the serial core
  assign differential_transceiver_mode_o = dec_q[0];
  assign receiver_on_o = dec_q[1];
  assign transmitter_on_o = dec_q[2];
  assign frame_start_detect_on_o = dec_q[3];
  assign multiprocessor_address_filter_o = dec_q[4];
  assign double_speed_o = dec_q[5];
  assign generic_autobaud_o = dec_q[6];
  assign lin_constrained_autobaud_o = dec_q[7];
  assign async_mode_o = dec_q[8];
  assign sync_mode_o = dec_q[9];
  assign infrared_mode_o = dec_q[10];
  assign host_spi_mode_o = dec_q[11];

  // Frame format and host SPI layout decodes
  assign parity_on_o = dec_q[12];
  assign parity_odd_o = dec_q[13];
  assign parity_reserved_o = dec_q[14];
  assign two_stop_bits_o = dec_q[15];
  assign nine_bit_low_first_o = dec_q[16];
  assign nine_bit_high_first_o = dec_q[17];
  assign spi_lsb_first_o = dec_q[18];
  assign spi_sample_trailing_o = dec_q[19];
  assign character_width_o = width_q;

endmodule // uctl_top

// [rtl/uctl_defs.vh]
// Constants for the serial port control-register block
// Overview of operation
// - Receive-done enable bit 7 gates the receive-done flag onto the interrupt request.
// - Transmit-done enable bit 6 gates the transmit-done flag onto the interrupt request.
// - Holding-empty enable bit 5 gates the holding-empty flag onto the interrupt request.
// - Frame-start enable bit 4 gates the receive-start flag onto the interrupt request.
// - Loop-back bit 3 feeds receiver from transmit output, ignoring the receive pin.
// - Auto-baud error enable bit 2 gates the sync-field error flag onto the request.
// - Bit 0 of first control register turns differential transceiver mode on or off.
// - Bit 7 of second control register turns the receiver on or off.
// - Bit 6 of second control register turns the transmitter on or off.
// - Bit 4 of second control register turns start-of-frame detection on or off.
// - Bit 3 of second control register selects open-drain or push-pull transmit drive.
// - Receiver mode bits 2:1 pick normal, double speed, generic or LIN auto-baud.
// - Bit 0 of second control register turns multiprocessor address filtering on or off.
// - Mode bits 7:6 of third register pick asynchronous, synchronous, infrared or host SPI.
// - Host SPI mode swaps the third register to its SPI field layout.
// - Parity bits 5:4 pick none, even or odd; value one is reserved.
// - Stop bit 3 gives one or two transmitted stop bits; receiver ignores it.
// - Character size field gives five to eight bits, or nine low or high first.
`ifndef UCTL_DEFS_VH
`define UCTL_DEFS_VH
// Register indexes; byte address is four times the index
`define UCTL_IDX_STATUS 4'h4
`define UCTL_IDX_CTRL_A 4'h5
`define UCTL_IDX_CTRL_B 4'h6
`define UCTL_IDX_CTRL_C 4'h7
`define UCTL_IDX_PENDING 4'hE
// Reset values
`define UCTL_RST_CTRL_A 8'h00
`define UCTL_RST_CTRL_B 8'h00
`define UCTL_RST_CTRL_C 8'h03
`define UCTL_RST_CTRL_C_SPI 8'h02
// Writable bit masks (reserved bits read zero)
`define UCTL_MASK_CTRL_A 8'hFD
`define UCTL_MASK_CTRL_B 8'hDF
`define UCTL_MASK_CTRL_C 8'hFF
`define UCTL_MASK_CTRL_C_SPI 8'hC6
// First control register fields
`define UCTL_A_RXDONE_IE 7
`define UCTL_A_TXDONE_IE 6
`define UCTL_A_HOLD_IE 5
`define UCTL_A_START_IE 4
`define UCTL_A_LOOPBACK 3
`define UCTL_A_ABERR_IE 2
`define UCTL_A_DIFF 0
// Second control register fields
`define UCTL_B_RX_ON 7
`define UCTL_B_TX_ON 6
`define UCTL_B_SFD_ON 4
`define UCTL_B_OPEN_DRAIN 3
`define UCTL_B_RECEIVER_SPEED_SELECT_HI 2
`define UCTL_B_RECEIVER_SPEED_SELECT_LO 1
`define UCTL_B_MULTIPROCESSOR_ADDRESS_FILTER 0
// Third control register fields
`define UCTL_C_COMMUNICATION_MODE_SELECT_HI 7
`define UCTL_C_COMMUNICATION_MODE_SELECT_LO 6
`define UCTL_C_PAR_HI 5
`define UCTL_C_PAR_LO 4
`define UCTL_C_STOP 3
`define UCTL_C_SIZE_HI 2
`define UCTL_C_SIZE_LO 0
`define UCTL_C_SPI_ORDER 2
`define UCTL_C_SPI_PHASE 1
// Field encodings
`define UCTL_RXM_NORMAL 2'h0
`define UCTL_RXM_DOUBLE 2'h1
`define UCTL_RXM_GENERIC_AUTOBAUD 2'h2
`define UCTL_RXM_LIN_CONSTRAINED_AUTOBAUD 2'h3
`define UCTL_CM_ASYNC 2'h0
`define UCTL_CM_SYNC 2'h1
`define UCTL_CM_INFRARED 2'h2
`define UCTL_CM_SPI 2'h3
`define UCTL_PAR_NONE 2'h0
`define UCTL_PAR_RSVD 2'h1
`define UCTL_PAR_EVEN 2'h2
`define UCTL_PAR_ODD 2'h3
`define UCTL_CS_NINE_LOW 3'h6
`define UCTL_CS_NINE_HIGH 3'h7
`define UCTL_CS_WIDTH_BASE 4'h5
`define UCTL_CS_WIDTH_NINE 4'h9
// Status view bit positions
`define UCTL_S_RXDONE 7
`define UCTL_S_TXDONE 6
`define UCTL_S_HOLD 5
`define UCTL_S_START 4
`define UCTL_S_SYNCERR 3
`define UCTL_NUM_SRC 5
`endif

// [tb/uctl_station.sv]
// Remote serial station model on the line side of the control block
`timescale 1ns/1ps
module uctl_station (
  // Clock
  input wire clk_i,
  // Line from the block
  input wire txd_pin_i,
  input wire txd_pin_oe_i,
  // Line toward the block
  output wire rxd_o
);
  wire line_lvl;
  reg [7:0] pat_q = 8'hA5;
  // Released open-drain line floats up to the pull-up level
  assign line_lvl = txd_pin_oe_i ? txd_pin_i : 1'b1;
  // Pattern moves every cycle, so a stale pin value passes for a match only where two successive bits agree
  always @(posedge clk_i)
  begin
    pat_q <= {pat_q[6:0], ~pat_q[7] ^ line_lvl};
  end
  assign rxd_o = pat_q[0];
endmodule // uctl_station

// [tb/uctl_top_sva.sv]
// Port checker for the serial control block, bound to its top module
`timescale 1ns/1ps
module uctl_chk (
  // Clock and reset
  input wire clk_i,
  input wire reset_i,
  // Register bus
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  // Flags and lines
  input wire receive_done_flag_i,
  input wire transmit_done_flag_i,
  input wire holding_empty_flag_i,
  input wire receive_start_flag_i,
  input wire sync_field_error_flag_i,
  input wire tx_data_i,
  input wire rxd_pin_i,
  input wire txd_pin_o,
  input wire txd_pin_oe_o,
  input wire rx_data_o,
  input wire irq_o
);
  wire req = avs_read_i | avs_write_i;
  wire any_flag = receive_done_flag_i | transmit_done_flag_i | holding_empty_flag_i | receive_start_flag_i |
    sync_field_error_flag_i;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_wait_first;
    req && !$past(req) |-> avs_waitrequest_o;
  endproperty
  a_wait_first: assert property (p_wait_first) else $error("no wait state on first cycle");
  property p_wait_once;
    req && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_wait_once: assert property (p_wait_once) else $error("wait state longer than one cycle");
  property p_rd_upper;
    avs_readdata_o[31:8] == 24'h00_0000;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
  property p_irq_clear;
    !any_flag |=> !irq_o;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt without flag");
  property p_irq_cause;
    $rose(irq_o) |-> $past(any_flag);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt rose with no cause");
  property p_rx_path;
    !$past(reset_i) |-> (rx_data_o == $past(tx_data_i)) || (rx_data_o == $past(rxd_pin_i));
  endproperty
  a_rx_path: assert property (p_rx_path) else $error("receiver input from neither source");
  property p_pin_follow;
    !$past(reset_i) && txd_pin_o |-> $past(tx_data_i);
  endproperty
  a_pin_follow: assert property (p_pin_follow) else $error("pin high without transmit bit");
  property p_oe_low;
    txd_pin_oe_o && !txd_pin_o |-> !$past(tx_data_i);
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("pin driven low on a one bit");
endmodule // uctl_chk
bind uctl_top uctl_chk u_uctl_chk (.clk_i(clk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .receive_done_flag_i(receive_done_flag_i), .transmit_done_flag_i(transmit_done_flag_i),
  .holding_empty_flag_i(holding_empty_flag_i), .receive_start_flag_i(receive_start_flag_i),
  .sync_field_error_flag_i(sync_field_error_flag_i), .tx_data_i(tx_data_i), .rxd_pin_i(rxd_pin_i),
  .txd_pin_o(txd_pin_o), .txd_pin_oe_o(txd_pin_oe_o), .rx_data_o(rx_data_o), .irq_o(irq_o));

// [tb/uctl_top_test.sv]
// Self-checking bench for the serial control block
`timescale 1ns/1ps
module uctl_top_test;
  reg clk_i = 1'b0;
  reg reset_i = 1'b1;
  reg [5:0] adr = 6'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h0000_0000;
  reg [4:0] flg = 5'h00;
  reg txd = 1'b0;
  reg last_pin = 1'b0;
  reg [7:0] q;
  integer fails = 0;
  integer n_tests = 0;
  wire [31:0] rdat;
  wire wreq, pin, pin_oe, rxd, rxq, irq, da;
  wire [6:0] db;
  wire [11:0] dc;
  wire [3:0] cw;
  uctl_top u_uctl_top (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_byteenable_i(4'h1), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .receive_done_flag_i(flg[4]), .transmit_done_flag_i(flg[3]),
    .holding_empty_flag_i(flg[2]), .receive_start_flag_i(flg[1]), .sync_field_error_flag_i(flg[0]),
    .tx_data_i(txd), .rxd_pin_i(rxd), .txd_pin_o(pin), .txd_pin_oe_o(pin_oe), .rx_data_o(rxq), .irq_o(irq),
    .differential_transceiver_mode_o(da), .receiver_on_o(db[6]), .transmitter_on_o(db[5]),
    .frame_start_detect_on_o(db[4]), .multiprocessor_address_filter_o(db[3]), .double_speed_o(db[2]),
    .generic_autobaud_o(db[1]), .lin_constrained_autobaud_o(db[0]), .async_mode_o(dc[11]),
    .sync_mode_o(dc[10]), .infrared_mode_o(dc[9]), .host_spi_mode_o(dc[8]), .parity_on_o(dc[7]),
    .parity_odd_o(dc[6]), .parity_reserved_o(dc[5]), .two_stop_bits_o(dc[4]), .character_width_o(cw),
    .nine_bit_low_first_o(dc[3]), .nine_bit_high_first_o(dc[2]), .spi_lsb_first_o(dc[1]),
    .spi_sample_trailing_o(dc[0]));
  uctl_station u_uctl_station (.clk_i(clk_i), .txd_pin_i(pin), .txd_pin_oe_i(pin_oe), .rxd_o(rxd));
  // Clock and a record of the pin value the block saw last cycle
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) last_pin <= rxd;
  task test_done;
    begin
      if (fails == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e)
      begin
        fails = fails + 1;
        $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  // Request stands from one rising edge until waitrequest is sampled low at a later one
  task bus(input w, input [5:0] a, input [7:0] d);
    integer k;
    begin
      k = 0;
      @(posedge clk_i);
      adr <= a;
      wdat <= {24'h00_0000, d};
      wr <= w;
      rd <= !w;
      @(posedge clk_i);
      while (wreq !== 1'b0 && k < 50)
      begin
        @(posedge clk_i);
        k = k + 1;
      end
      if (k == 50)
        chk(1, 0);
      q = rdat[7:0];
      wr <= 1'b0;
      rd <= 1'b0;
    end
  endtask
  task rchk(input [5:0] a, input [7:0] e);
    begin
      bus(0, a, 8'h00);
      chk(q, e);
    end
  endtask
  // Decodes trail the write edge by one register
  task settle;
    begin
      repeat (3) @(negedge clk_i);
    end
  endtask
  task t_regs;
    begin
      rchk(6'h14, 8'h00);
      rchk(6'h18, 8'h00);
      rchk(6'h1C, 8'h03);
      chk({dc[11], cw}, 5'h18);
      bus(1, 6'h14, 8'hFF);
      rchk(6'h14, 8'hFD);
      settle;
      chk(da, 1);
      bus(1, 6'h20, 8'h5A);
      rchk(6'h20, 8'h00);
      bus(1, 6'h14, 8'h00);
    end
  endtask
  task t_irq;
    integer i;
    reg [7:0] en;
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        en = (i == 4) ? 8'h04 : 8'h80 >> i;
        @(posedge clk_i);
        flg <= 5'h10 >> i;
        settle;
        chk(irq, 0);
        bus(1, 6'h14, en);
        settle;
        chk(irq, 1);
        rchk(6'h38, 8'h80 >> i);
        bus(1, 6'h14, en ^ 8'hF4);
        settle;
        chk(irq, 0);
        rchk(6'h10, 8'h80 >> i);
        rchk(6'h38, 8'h00);
        bus(1, 6'h14, en);
        settle;
        chk(irq, 1);
        @(posedge clk_i);
        flg <= 5'h00;
        settle;
        chk(irq, 0);
      end
    end
  endtask
  task t_loop;
    integer i;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        bus(1, 6'h14, {4'h0, i[2], 3'h0});
        txd <= i[0];
        settle;
        chk(rxq, i[2] ? i[0] : last_pin);
      end
    end
  endtask
  task t_line;
    integer i;
    reg [7:0] b;
    begin
      for (i = 0; i < 6; i = i + 1)
      begin
        b = {1'b0, i > 1, 2'h0, i > 3, 3'h0};
        bus(1, 6'h18, b);
        txd <= i[0];
        settle;
        chk({pin, pin_oe, db[5]}, {!b[3] & i[0], b[6] & !(b[3] & i[0]), b[6]});
      end
    end
  endtask
  task t_direction_and_receive_mode_control;
    integer i;
    reg [7:0] v;
    begin
      bus(1, 6'h1C, 8'h43);
      for (i = 0; i < 4; i = i + 1)
      begin
        v = {i[0], !i[0], 1'b0, i[0], 1'b0, i[1:0], !i[0]};
        bus(1, 6'h18, v);
        rchk(6'h18, v);
        settle;
        chk(db, {v[7], v[6], v[4], v[0], v[2:1] == 1, v[2:1] == 2, v[2:1] == 3});
      end
      bus(1, 6'h18, 8'h00);
    end
  endtask
  task t_frame_format_control;
    integer i;
    reg [7:0] v;
    reg [15:0] ex;
    begin
      for (i = 0; i < 8; i = i + 1)
      begin
        v = {(i[1:0] == 3) ? 2'h2 : i[1:0], i[1:0], i[0], i[2:0]};
        ex = {v[7:6] == 0, v[7:6] == 1, v[7:6] == 2, 1'b0, v[5], v[5:4] == 3, v[5:4] == 1, v[3],
          v[2:0] == 6, v[2:0] == 7, 2'h0, (v[2:0] < 4) ? {1'b0, v[2:0]} + 4'h5 : (v[2:0] > 5) ? 4'h9 : 4'h0};
        bus(1, 6'h1C, v);
        settle;
        chk({dc, cw}, ex);
      end
      bus(1, 6'h1C, 8'hFF);
      rchk(6'h1C, 8'hC6);
      settle;
      chk({dc, cw}, 16'h1030);
      bus(1, 6'h1C, 8'hC4);
      settle;
      chk({dc, cw}, 16'h1020);
      bus(1, 6'h1C, 8'h03);
    end
  endtask
  // Mid-run reset brings the first and third control registers back to their reset values
  task t_reset;
    begin
      bus(1, 6'h14, 8'hFF);
      bus(1, 6'h1C, 8'h00);
      @(posedge clk_i);
      reset_i <= 1'b1;
      repeat (16) @(posedge clk_i);
      chk(dc[11], 0);
      reset_i <= 1'b0;
      rchk(6'h14, 8'h00);
      rchk(6'h1C, 8'h03);
      settle;
      chk({dc[11], cw}, 5'h18);
    end
  endtask
  // Watchdog cuts a hang short
  initial
  begin
    repeat (20000) @(posedge clk_i);
    fails = fails + 1;
    test_done;
  end
  initial
  begin
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs;
    t_irq;
    t_loop;
    t_line;
    t_direction_and_receive_mode_control;
    t_frame_format_control;
    t_reset;
    test_done;
  end
endmodule // uctl_top_test
